// *** core/tlvi_irq_unit.v ***
// Purpose: nested two-level vectored interrupt controller with APB registers
// Assumes: pclk is the machine cycle; CPU signals entry and end of service
// Notes: zero-wait APB slave; vector and request come from flip-flops
// Summary of operation
// - Thirteen sources: two external, two timers, serial port, eight port lines.
// - Two priority levels with nesting of service routines.
// - Each source has its own fixed vector address.
// - Equal-priority ties resolved by fixed polling order.
// - High-priority request wins over simultaneous low-priority request.
// - Low routine pre-empted only by high; high routine never pre-empted.
// - Global gate bit 7 blocks all acceptance when zero.
// - Main enable register holds enables of the five fixed sources.
// - Port enable register bits 7..0 enable port lines 9..2.
// - Main priority register holds levels of the five fixed sources.
// - Port priority register bits 7..0 set levels of port lines 9..2.
// - Each port line may request, active level individually programmable.
// - Enabled port request raises wake-up from power-down.
// - Port flag set by hardware on request; only software clears it. Here a flag sets only while its line's port enable bit is set.
// - Port requests are levels held active at least one machine cycle.
// - Recognised port request serviced no earlier than next machine cycle.
// - Polarity bit one means active high, zero means active low.
// - Polarity register bits 7..0 belong to port lines 9..2.
// - Request flag register bits 7..0 hold pending flags of lines 9..2.
//
// The APB register port is this design's own decision.
`default_nettype none
`include "tlvi_consts.vh"

module tlvi_irq_unit
(
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Fixed sources (same clock domain)
    input wire ext_request_0,
    input wire ext_request_1,
    input wire timer_a_req,
    input wire timer_b_req,
    input wire serial_port_req,
    // Port-1 request pins
    input wire [7:0] port_ext_requests,
    // CPU core handshake
    input wire irq_ack,
    input wire irq_return,
    output reg irq_req_ff,
    output reg [15:0] irq_vector_ff,
    output reg [3:0] irq_source_ff,
    // Power-down wake
    output reg wake_ff
);

// ==========================================================
// Registers
// ==========================================================
reg [7:0] main_irq_enable_ff;
reg [7:0] main_irq_priority_ff;
reg [7:0] port_irq_request_flags_ff;
reg [7:0] port_irq_enable_ff;
reg [7:0] port_irq_polarity_ff;
reg [7:0] port_irq_priority_ff;
reg [7:0] port_active_ff;
// Nesting state: one bit per level that has a routine in progress
reg in_high_ff;
reg in_low_ff;
wire [7:0] port_level;

// Pin synchroniser
tlvi_port_sync u_sync
(
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in(port_ext_requests),
    .level_ff(port_level)
);

// ==========================================================
// Helpers
// ==========================================================
// Byte address of a register index
function [`TLVI_ADDR_W-1:0] reg_addr;
    input [7:0] idx;
    begin
        reg_addr = {idx, 2'b00};
    end
endfunction

// Vector of a source numbered in polling order
function [15:0] src_vector;
    input [3:0] src;
    begin
        case (src)
            4'h0: src_vector = `TLVI_VEC_EXT0;
            4'h1: src_vector = `TLVI_VEC_SER;
            4'h2: src_vector = `TLVI_VEC_PORT_BASE + 16'h0003 * `TLVI_VEC_STEP;
            4'h3: src_vector = `TLVI_VEC_TMR0;
            4'h4: src_vector = `TLVI_VEC_PORT_BASE + 16'h0004 * `TLVI_VEC_STEP;
            4'h5: src_vector = `TLVI_VEC_EXT1;
            4'h6: src_vector = `TLVI_VEC_PORT_BASE;
            4'h7: src_vector = `TLVI_VEC_PORT_BASE + 16'h0005 * `TLVI_VEC_STEP;
            4'h8: src_vector = `TLVI_VEC_TMR1;
            4'h9: src_vector = `TLVI_VEC_PORT_BASE + 16'h0001 * `TLVI_VEC_STEP;
            4'ha: src_vector = `TLVI_VEC_PORT_BASE + 16'h0006 * `TLVI_VEC_STEP;
            4'hb: src_vector = `TLVI_VEC_PORT_BASE + 16'h0002 * `TLVI_VEC_STEP;
            4'hc: src_vector = `TLVI_VEC_PORT_BASE + 16'h0007 * `TLVI_VEC_STEP;
            default: src_vector = 16'h0000;
        endcase
    end
endfunction

// First set bit, lowest index polled first
function [3:0] first_set;
    input [12:0] vec;
    integer i;
    begin
        first_set = `TLVI_NO_SRC;
        for (i = `TLVI_NSRC - 1; i >= 0; i = i - 1)
            if (vec[i])
                first_set = i[3:0];
    end
endfunction

// Reorders five fixed-source bits and eight port-line bits into polling order
// Fixed bits from 0 up: ext0, serial, timer0, ext1, timer1; port bit k is line k+2
// One function keeps pending, enable and priority vectors in the same order
function [12:0] poll_order;
    input [4:0] fixed;
    input [7:0] port;
    begin
        poll_order[0] = fixed[0]; // ext0, polled first
        poll_order[1] = fixed[1]; // serial port
        poll_order[2] = port[3]; // line 5
        poll_order[3] = fixed[2]; // timer 0
        poll_order[4] = port[4]; // line 6
        poll_order[5] = fixed[3]; // ext1
        poll_order[6] = port[0]; // line 2
        poll_order[7] = port[5]; // line 7
        poll_order[8] = fixed[4]; // timer 1
        poll_order[9] = port[1]; // line 3
        poll_order[10] = port[6]; // line 8
        poll_order[11] = port[2]; // line 4
        poll_order[12] = port[7]; // line 9, polled last
    end
endfunction

// ==========================================================
// Source assembly in polling order
// ==========================================================
wire global_irq_gate = main_irq_enable_ff[`TLVI_BIT_GLOBAL];
wire [7:0] port_hit = ~(port_level ^ port_irq_polarity_ff);
wire [7:0] pf = port_irq_request_flags_ff;
wire [7:0] pe = port_irq_enable_ff;
wire [7:0] pp = port_irq_priority_ff;
wire [7:0] me = main_irq_enable_ff;
wire [7:0] mp = main_irq_priority_ff;
// Fixed sources packed ext0, serial, timer0, ext1, timer1 from bit 0 up
wire [4:0] fix_pend = {timer_b_req, ext_request_1, timer_a_req, serial_port_req, ext_request_0};
wire [4:0] fix_enab = {me[`TLVI_BIT_TIMER_B], me[`TLVI_BIT_EXT_B], me[`TLVI_BIT_TIMER_A], me[`TLVI_BIT_SERIAL],
    me[`TLVI_BIT_EXT_A]};
wire [4:0] fix_prio = {mp[`TLVI_BIT_TIMER_B], mp[`TLVI_BIT_EXT_B], mp[`TLVI_BIT_TIMER_A], mp[`TLVI_BIT_SERIAL],
    mp[`TLVI_BIT_EXT_A]};
// All thirteen sources in polling order, index 0 polled first
wire [12:0] pend = poll_order(fix_pend, pf);
wire [12:0] enab = poll_order(fix_enab, pe);
wire [12:0] prio = poll_order(fix_prio, pp);
wire [12:0] live = pend & enab & {13{global_irq_gate}};
// Port lines that were active last cycle still qualify only through their flags
wire [12:0] hi_req = live & prio & {13{~in_high_ff}};
wire [12:0] lo_req = live & ~prio & {13{~in_high_ff & ~in_low_ff}};
wire [3:0] hi_win = first_set(hi_req);
wire [3:0] lo_win = first_set(lo_req);
// A high-level winner always beats any low-level one
wire win_high = (hi_win != `TLVI_NO_SRC);
wire [3:0] win = win_high ? hi_win : lo_win;

// ==========================================================
// APB decode
// ==========================================================
wire [`TLVI_ADDR_W-1:0] addr = paddr[`TLVI_ADDR_W-1:0];
wire wr = psel & penable & pwrite;
wire rd = psel & ~penable & ~pwrite;
// Register hits on the full byte address, low two bits included; upper address bits must be zero as well
wire hit_men = (addr == reg_addr(`TLVI_IDX_MAIN_EN));
wire hit_mpr = (addr == reg_addr(`TLVI_IDX_MAIN_PRI));
wire hit_flg = (addr == reg_addr(`TLVI_IDX_PORT_FLAGS));
wire hit_pen = (addr == reg_addr(`TLVI_IDX_PORT_EN));
wire hit_pol = (addr == reg_addr(`TLVI_IDX_PORT_POL));
wire hit_ppr = (addr == reg_addr(`TLVI_IDX_PORT_PRI));
wire hit_svc = (addr == reg_addr(`TLVI_IDX_SERVICE));
wire hit_any = hit_men | hit_mpr | hit_flg | hit_pen | hit_pol | hit_ppr | hit_svc;
wire upper_zero = (paddr[31:`TLVI_ADDR_W] == 22'h000000);
wire mapped = hit_any & upper_zero;
// Write strobes, only at the access edge and only for a mapped register
wire wr_men = wr & mapped & hit_men;
wire wr_mpr = wr & mapped & hit_mpr;
wire wr_flg = wr & mapped & hit_flg;
wire wr_pen = wr & mapped & hit_pen;
wire wr_pol = wr & mapped & hit_pol;
wire wr_ppr = wr & mapped & hit_ppr;

// Read mux
reg [7:0] rd_byte;
always @*
begin
    rd_byte = 8'h00;
    if (upper_zero)
    begin
        if (hit_men) rd_byte = main_irq_enable_ff;
        if (hit_mpr) rd_byte = main_irq_priority_ff;
        if (hit_flg) rd_byte = port_irq_request_flags_ff;
        if (hit_pen) rd_byte = port_irq_enable_ff;
        if (hit_pol) rd_byte = port_irq_polarity_ff;
        if (hit_ppr) rd_byte = port_irq_priority_ff;
        if (hit_svc) rd_byte = {6'h00, in_high_ff, in_low_ff};
    end
end

// ==========================================================
// Register writes and port flags
// ==========================================================
// Set wins over a simultaneous software clear, so no request is lost
wire [7:0] flag_set = port_active_ff & port_hit & pe;
wire [7:0] nxt_flags = (wr_flg ? pwdata[7:0] & pf : pf) | flag_set;

// Configuration registers; reserved main bits are dropped on write
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        main_irq_enable_ff <= `TLVI_RESET_VAL;
        main_irq_priority_ff <= `TLVI_RESET_VAL;
        port_irq_enable_ff <= `TLVI_RESET_VAL;
        port_irq_polarity_ff <= `TLVI_RESET_VAL;
        port_irq_priority_ff <= `TLVI_RESET_VAL;
    end
    else if (clk_en)
    begin
        if (wr_men) main_irq_enable_ff <= pwdata[7:0] & `TLVI_MAIN_EN_MASK;
        if (wr_mpr) main_irq_priority_ff <= pwdata[7:0] & `TLVI_MAIN_PRI_MASK;
        if (wr_pen) port_irq_enable_ff <= pwdata[7:0];
        if (wr_pol) port_irq_polarity_ff <= pwdata[7:0];
        if (wr_ppr) port_irq_priority_ff <= pwdata[7:0];
    end
end

// Port line qualification and request flags
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        port_irq_request_flags_ff <= `TLVI_RESET_VAL;
        port_active_ff <= `TLVI_RESET_VAL;
    end
    else if (clk_en)
    begin
        // One full cycle at the active level before the flag sets
        port_active_ff <= port_hit;
        port_irq_request_flags_ff <= nxt_flags;
    end
end

// ==========================================================
// APB answer
// ==========================================================
// Read data captured in setup so the access phase is zero-wait
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~mapped;
        if (rd)
            prdata <= {24'h000000, rd_byte};
    end
end

// ==========================================================
// Nesting state and CPU request
// ==========================================================
// Next nesting level: a return pops the innermost level, then an entry pushes
// its own, so a return that meets an entry in one cycle is not lost
reg nxt_in_high;
reg nxt_in_low;
always @*
begin
    nxt_in_high = in_high_ff;
    nxt_in_low = in_low_ff;
    if (irq_return)
    begin
        if (in_high_ff)
            nxt_in_high = 1'b0;
        else
            nxt_in_low = 1'b0;
    end
    if (irq_ack & irq_req_ff)
    begin
        if (prio[irq_source_ff])
            nxt_in_high = 1'b1;
        else
            nxt_in_low = 1'b1;
    end
end

// Request to the CPU drops for a cycle on entry and on return
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        in_high_ff <= 1'b0;
        in_low_ff <= 1'b0;
        irq_req_ff <= 1'b0;
        irq_vector_ff <= 16'h0000;
        irq_source_ff <= `TLVI_NO_SRC;
        wake_ff <= 1'b0;
    end
    else if (clk_en)
    begin
        wake_ff <= |(pf & pe) | |flag_set;
        in_high_ff <= nxt_in_high;
        in_low_ff <= nxt_in_low;
        if (irq_ack & irq_req_ff)
            irq_req_ff <= 1'b0;
        else
        begin
            irq_req_ff <= (win != `TLVI_NO_SRC) & ~irq_return;
            irq_vector_ff <= src_vector(win);
            irq_source_ff <= win;
        end
    end
end

endmodule // tlvi_irq_unit
`default_nettype wire

// *** core/tlvi_port_sync.v ***
// Purpose: three-flop synchroniser with agreement filter for port-1 lines
// Assumes: pins asynchronous to pclk
// Notes: first stage feeds only the second stage
`default_nettype none

module tlvi_port_sync
(
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // Pins
    input wire [7:0] pin_in,
    // Stable levels
    output reg [7:0] level_ff
);

reg [7:0] meta_ff;
reg [7:0] s2_ff;
reg [7:0] s3_ff;

// ==========================================================
// Synchroniser chain
// ==========================================================
// A level is taken only when stages two and three agree
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_ff <= 8'h00;
        s2_ff <= 8'h00;
        s3_ff <= 8'h00;
        level_ff <= 8'h00;
    end
    else if (clk_en)
    begin
        meta_ff <= pin_in;
        s2_ff <= meta_ff;
        s3_ff <= s2_ff;
        level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
    end
end

endmodule // tlvi_port_sync
`default_nettype wire

// *** include/tlvi_consts.vh ***
// Purpose: constants for the two-level vectored interrupt unit
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits
// Notes: definitions only
`ifndef TLVI_CONSTS_VH
`define TLVI_CONSTS_VH

// ==========================================================
// Register indices (printed offsets) and byte addresses
// ==========================================================
`define TLVI_IDX_MAIN_EN 8'ha8
`define TLVI_IDX_MAIN_PRI 8'hb8
`define TLVI_IDX_PORT_FLAGS 8'hc0
`define TLVI_IDX_PORT_EN 8'he8
`define TLVI_IDX_PORT_POL 8'he9
`define TLVI_IDX_PORT_PRI 8'hf8
`define TLVI_IDX_SERVICE 8'hfc
`define TLVI_ADDR_W 10

// ==========================================================
// Field positions and masks
// ==========================================================
`define TLVI_BIT_GLOBAL 7
`define TLVI_BIT_SERIAL 5
`define TLVI_BIT_TIMER_B 3
`define TLVI_BIT_EXT_B 2
`define TLVI_BIT_TIMER_A 1
`define TLVI_BIT_EXT_A 0
`define TLVI_MAIN_EN_MASK 8'haf
`define TLVI_MAIN_PRI_MASK 8'h2f
`define TLVI_RESET_VAL 8'h00

// ==========================================================
// Source numbering in polling order (0 polled first)
// ==========================================================
`define TLVI_NSRC 13
`define TLVI_SRC_W 4
`define TLVI_NO_SRC 4'hf

// ==========================================================
// Vector addresses
// ==========================================================
`define TLVI_VEC_EXT0 16'h0003
`define TLVI_VEC_TMR0 16'h000b
`define TLVI_VEC_EXT1 16'h0013
`define TLVI_VEC_TMR1 16'h001b
`define TLVI_VEC_SER 16'h002b
`define TLVI_VEC_PORT_BASE 16'h003b
`define TLVI_VEC_STEP 16'h0008

`endif

// *** tb/tlvi_cpu_model.sv ***
// Purpose: CPU core stand-in for the interrupt unit
// Assumes: bench asks for entry and return one pulse at a time
// Notes: acks only a request that is actually presented
`default_nettype none

module tlvi_cpu_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench controls
    input wire logic go_ack,
    input wire logic go_ret,
    // Controller side
    input wire logic irq_req_ff,
    input wire logic [15:0] irq_vector_ff,
    output logic irq_ack,
    output logic irq_return,
    output logic [15:0] last_vec
);
    timeunit 1ns;
    timeprecision 1ps;

    // Single-cycle pulses, so an entry is never taken twice
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            last_vec <= 16'h0000;
        end
        else
        begin
            irq_ack <= go_ack && irq_req_ff && !irq_ack;
            irq_return <= go_ret && !irq_return;
            if (go_ack && irq_req_ff && !irq_ack)
                last_vec <= irq_vector_ff;
        end
    end
endmodule // tlvi_cpu_model
`default_nettype wire

// *** tb/tlvi_irq_unit_props.sv ***
// Purpose: port-level assertions for the interrupt unit
// Assumes: one pclk domain, async active-low reset
// Notes: attached by the bind at the foot
`default_nettype none

module tlvi_irq_unit_props
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // CPU side
    input wire logic irq_ack,
    input wire logic irq_req_ff,
    input wire logic [15:0] irq_vector_ff,
    input wire logic [3:0] irq_source_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ack_drops_req: assert property (clk_en && irq_ack && irq_req_ff |=> !irq_req_ff)
        else $error("request held after ack");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    a_zero_wait: assert property (clk_en && psel && !penable |=> pready)
        else $error("access phase not answered");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_req: assert property (irq_source_ff == 4'hf |-> !irq_req_ff)
        else $error("request with no source");
    a_vec_ext0: assert property (irq_req_ff && irq_source_ff == 4'h0 |-> irq_vector_ff == 16'h0003)
        else $error("wrong vector for ext0");
    a_vec_serial: assert property (irq_req_ff && irq_source_ff == 4'h1 |-> irq_vector_ff == 16'h002b)
        else $error("wrong vector for serial");
    a_vec_port5: assert property (irq_req_ff && irq_source_ff == 4'h2 |-> irq_vector_ff == 16'h0053)
        else $error("wrong vector for port5");
    a_vec_timer_b: assert property (irq_req_ff && irq_source_ff == 4'h8 |-> irq_vector_ff == 16'h001b)
        else $error("wrong vector for timer b");
    a_freeze_req: assert property (!clk_en |=> $stable(irq_req_ff) && $stable(irq_vector_ff))
        else $error("request moved while frozen");
    // Main scenarios reached
    c_entry: cover property (irq_ack && irq_req_ff);
    c_unmapped: cover property (pslverr);
    c_frozen: cover property (!clk_en);
endmodule // tlvi_irq_unit_props
bind tlvi_irq_unit tlvi_irq_unit_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack), .irq_req_ff(irq_req_ff),
    .irq_vector_ff(irq_vector_ff), .irq_source_ff(irq_source_ff));
`default_nettype wire

// *** tb/tlvi_irq_unit_tb.sv ***
// Purpose: self-checking bench for the interrupt unit
// Assumes: zero-wait APB, CPU model for entry and return
// Notes: fixed waits follow the stated request latencies
`default_nettype none
`include "tlvi_consts.vh"

module tlvi_irq_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err, go_ack = 0, go_ret = 0;
    logic e0 = 0, e1 = 0, ta = 0, tb = 0, ser = 0, pready, pslverr, irq_ack, irq_return, irq_req_ff, wake_ff;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [7:0] pins = 8'hff;
    logic [15:0] irq_vector_ff, last_vec;
    logic [3:0] irq_source_ff;
    logic [7:0] regs [6] = '{`TLVI_IDX_MAIN_EN, `TLVI_IDX_MAIN_PRI, `TLVI_IDX_PORT_FLAGS, `TLVI_IDX_PORT_EN,
        `TLVI_IDX_PORT_POL, `TLVI_IDX_PORT_PRI};
    logic [7:0] msk [6] = '{8'haf, 8'h2f, 8'h00, 8'hff, 8'hff, 8'hff};
    int num_errors = 0, checks = 0;
    // ==========================================================
    // Clock, design and CPU
    // ==========================================================
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    tlvi_irq_unit DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_request_0(e0), .ext_request_1(e1), .timer_a_req(ta), .timer_b_req(tb), .serial_port_req(ser),
        .port_ext_requests(pins), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req_ff(irq_req_ff),
        .irq_vector_ff(irq_vector_ff), .irq_source_ff(irq_source_ff), .wake_ff(wake_ff));
    tlvi_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .go_ack(go_ack), .go_ret(go_ret),
        .irq_req_ff(irq_req_ff), .irq_vector_ff(irq_vector_ff), .irq_ack(irq_ack), .irq_return(irq_return),
        .last_vec(last_vec));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(0, idx, 0);
        chk("register", rd, exp);
    endtask
    // Waits past the stated request latency, then compares
    task automatic ichk(input logic req, input logic [15:0] vec);
        repeat (4) @(posedge pclk);
        chk("request", {31'h0, irq_req_ff}, {31'h0, req});
        if (req)
            chk("vector", {16'h0, irq_vector_ff}, {16'h0, vec});
    endtask
    // Request stands for one sampled edge, so the CPU model acts exactly once
    task automatic pulse(input logic ack);
        if (ack)
            go_ack <= 1;
        else
            go_ret <= 1;
        @(posedge pclk);
        go_ack <= 0;
        go_ret <= 0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic final_report;
        if (num_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        foreach (regs[i]) rchk(regs[i], 0);
        chk("wake", {31'h0, wake_ff}, 0);
        for (int i = 0; i < 6; i++)
        begin
            apb(1, regs[i], 32'hff);
            rchk(regs[i], {24'h0, msk[i]});
            apb(1, regs[i], 0);
        end
        apb(0, 8'h01, 0);
        chk("error", {31'h0, err}, 1);
        chk("data", rd, 0);
        {e0, e1, ta, tb, ser} <= 5'h1f;
        apb(1, `TLVI_IDX_MAIN_EN, 32'h2f);
        ichk(0, 0);
        apb(1, `TLVI_IDX_MAIN_EN, 32'haf);
        clk_en <= 0;
        ichk(0, 0);
        clk_en <= 1;
        ichk(1, `TLVI_VEC_EXT0);
        e0 <= 0;
        ichk(1, `TLVI_VEC_SER);
        ser <= 0;
        ichk(1, `TLVI_VEC_TMR0);
        ta <= 0;
        ichk(1, `TLVI_VEC_EXT1);
        e1 <= 0;
        ichk(1, `TLVI_VEC_TMR1);
        {e0, e1, ta, ser} <= 4'hf;
        apb(1, `TLVI_IDX_MAIN_PRI, 32'h08);
        ichk(1, `TLVI_VEC_TMR1);
        tb <= 0;
        ichk(1, `TLVI_VEC_EXT0);
        pulse(1);
        chk("entry", {16'h0, last_vec}, {16'h0, `TLVI_VEC_EXT0});
        ichk(0, 0);
        rchk(`TLVI_IDX_SERVICE, 1);
        tb <= 1;
        ichk(1, `TLVI_VEC_TMR1);
        pulse(1);
        rchk(`TLVI_IDX_SERVICE, 3);
        ichk(0, 0);
        pulse(0);
        rchk(`TLVI_IDX_SERVICE, 1);
        ichk(1, `TLVI_VEC_TMR1);
        tb <= 0;
        pulse(0);
        ichk(1, `TLVI_VEC_EXT0);
        rchk(`TLVI_IDX_SERVICE, 0);
        {e0, e1, ta, ser} <= 4'h0;
        apb(1, `TLVI_IDX_PORT_POL, 32'h08);
        apb(1, `TLVI_IDX_PORT_EN, 32'h08);
        repeat (12) @(posedge pclk);
        rchk(`TLVI_IDX_PORT_FLAGS, 32'h08);
        chk("wake", {31'h0, wake_ff}, 1);
        ta <= 1;
        ichk(1, 16'h0053);
        ta <= 0;
        pins <= 8'hf6;
        repeat (12) @(posedge pclk);
        rchk(`TLVI_IDX_PORT_FLAGS, 32'h08);
        apb(1, `TLVI_IDX_PORT_FLAGS, 0);
        rchk(`TLVI_IDX_PORT_FLAGS, 0);
        apb(1, `TLVI_IDX_PORT_EN, 32'h01);
        repeat (12) @(posedge pclk);
        rchk(`TLVI_IDX_PORT_FLAGS, 32'h01);
        e0 <= 1;
        ichk(1, `TLVI_VEC_EXT0);
        apb(1, `TLVI_IDX_PORT_PRI, 32'h01);
        ichk(1, 16'h003b);
        final_report();
    end
    // Cuts a hang well past the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule // tlvi_irq_unit_tb
`default_nettype wire
